// [design/tsi_regs.svh]
// register offsets, field positions, reset values and codes of the touch-controller serial port
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH
`define TSI_DEF_SLAVE_ADDR 7'h2B
`define TSI_NVM_ADDR_LOC 8'h04
`define TSI_OFS_IRQ 8'h00
`define TSI_OFS_KEYS 8'h01
`define TSI_OFS_MEMST 8'h08
`define TSI_OFS_OPMODE 8'h09
`define TSI_OFS_GPO 8'h0A
`define TSI_OFS_GWCFG 8'h0D
`define TSI_OFS_GWBASE 8'h0E
`define TSI_OFS_KEYHI 8'hAC
`define TSI_OFS_KEYLO 8'hAD
`define TSI_OFS_SRST 8'hB1
`define TSI_IRQ_BURN 6
`define TSI_IRQ_PWRITE 5
`define TSI_IRQ_SENSOR 2
`define TSI_IRQ_COMP 1
`define TSI_IRQ_MODE 0
`define TSI_KEY_PRIO 6
`define TSI_MEM_VALID 3
`define TSI_BURN_MAX 3'h3
`define TSI_BURN_OVER 3'h4
`define TSI_SRST_ARM 8'hDE
`define TSI_SRST_FIRE 8'h00
`define TSI_RST_BYTE 8'h00
`define TSI_BITS_PER_BYTE 4'h8
`endif

// [design/tsi_pkg.sv]
// types shared by the touch-controller serial port
`default_nettype none
package tsi_pkg;
   // one-hot protocol states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK = 6'h04,
      ST_WR = 6'h08,
      ST_RD = 6'h10,
      ST_MACK = 6'h20
   } tsi_state_t;
   // one-cycle event pulses from the sensing core
   typedef struct packed {
      logic burn_done;
      logic param_write_done;
      logic sensor_event;
      logic comp_done;
      logic mode_entered;
   } tsi_evt_t;
   // control values handed to the core at a processing phase
   typedef struct packed {
      logic [7:0] op_mode;
      logic [7:0] gpo;
      logic [7:0] gw_cfg;
      logic [7:0] gw_base;
      logic [7:0] key_hi;
      logic [7:0] key_lo;
   } tsi_ctrl_t;
endpackage
`default_nettype wire

// [design/tsi_sync.sv]
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module tsi_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   // pins idle high, so both stages reset high
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '1;
         q_ff <= '1;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end
   assign q = q_ff;
endmodule
`default_nettype wire

// [design/tsi_slave.sv]
// two-wire slave port and register file of the touch controller
`timescale 1ns/1ps
`default_nettype none
`include "tsi_regs.svh"
module tsi_slave #(
   parameter int KEYS = 36
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // serial pins, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // interrupt request pin, open drain
   output logic interrupt_request_o,
   output logic interrupt_request_oe_n,
   // sensing core status
   input wire tsi_pkg::tsi_evt_t events,
   input wire logic priority_touched,
   input wire logic [KEYS-1:0] keys_touched,
   input wire logic nonvolatile_valid,
   input wire logic [2:0] burn_count,
   input wire logic stored_addr_valid,
   input wire logic [6:0] stored_addr,
   // processing phase and control hand-off
   input wire logic phase_start,
   output tsi_pkg::tsi_ctrl_t ctrl,
   output logic soft_reset_pulse
);
   // ********************************************************
   // pin sampling and bus conditions
   // ********************************************************
   logic scl_s;
   logic sda_s;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // 8 ns sampling resolves 400 kb/s edges with margin
   tsi_sync #(.W(2)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({scl_i, sda_i}),
      .q({scl_s, sda_s})
   );

   // previous synchronised levels for edge detection
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_ff;
   assign scl_fall = ~scl_s & scl_d_ff;
   assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // ********************************************************
   // protocol engine
   // ********************************************************
   tsi_pkg::tsi_state_t st_ff;
   logic [7:0] shreg_ff;
   logic [7:0] txreg_ff;
   logic [3:0] cnt_ff;
   logic [7:0] ptr_ff;
   logic rw_ff;
   logic first_ff;
   logic ack_rise_ff;
   logic more_ff;
   logic sda_oe_n_ff;
   logic [6:0] my_addr;
   logic [7:0] rd_data;
   logic byte_done;
   logic wr_go;
   logic rd_go;

   // a stored address wins over the default
   assign my_addr = stored_addr_valid ? stored_addr : `TSI_DEF_SLAVE_ADDR;
   assign byte_done = scl_fall && (cnt_ff == `TSI_BITS_PER_BYTE);
   assign wr_go = (st_ff == tsi_pkg::ST_WR) && byte_done && !first_ff;
   // a byte is fetched after the address ack, or after a master ack
   assign rd_go = scl_fall && (((st_ff == tsi_pkg::ST_ACK) && ack_rise_ff && rw_ff)
                  || ((st_ff == tsi_pkg::ST_MACK) && more_ff));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= tsi_pkg::ST_IDLE;
         shreg_ff <= 8'h00;
         txreg_ff <= 8'h00;
         cnt_ff <= 4'h0;
         ptr_ff <= 8'h00;
         rw_ff <= 1'b0;
         first_ff <= 1'b0;
         ack_rise_ff <= 1'b0;
         more_ff <= 1'b0;
         sda_oe_n_ff <= 1'b1;
      end else if (start_c) begin
         // start and repeated start both restart address reception
         st_ff <= tsi_pkg::ST_ADDR;
         cnt_ff <= 4'h0;
         first_ff <= 1'b1;
         sda_oe_n_ff <= 1'b1;
      end else if (stop_c) begin
         st_ff <= tsi_pkg::ST_IDLE;
         sda_oe_n_ff <= 1'b1;
      end else begin
         unique case (st_ff)
            tsi_pkg::ST_IDLE: begin
               sda_oe_n_ff <= 1'b1;
            end
            tsi_pkg::ST_ADDR, tsi_pkg::ST_WR: begin
               if (scl_rise) begin
                  shreg_ff <= {shreg_ff[6:0], sda_s};
                  cnt_ff <= cnt_ff + 4'h1;
               end else if (byte_done) begin
                  if (st_ff == tsi_pkg::ST_ADDR) begin
                     // only our own address is answered
                     if (shreg_ff[7:1] == my_addr) begin
                        rw_ff <= shreg_ff[0];
                        st_ff <= tsi_pkg::ST_ACK;
                        sda_oe_n_ff <= 1'b0;
                     end else begin
                        st_ff <= tsi_pkg::ST_IDLE;
                     end
                  end else begin
                     if (first_ff) begin
                        ptr_ff <= shreg_ff;
                        first_ff <= 1'b0;
                     end else begin
                        ptr_ff <= ptr_ff + 8'h01;
                     end
                     // every byte is acknowledged, reserved targets too
                     st_ff <= tsi_pkg::ST_ACK;
                     sda_oe_n_ff <= 1'b0;
                  end
                  ack_rise_ff <= 1'b0;
               end
            end
            tsi_pkg::ST_ACK: begin
               if (scl_rise) begin
                  ack_rise_ff <= 1'b1;
               end else if (rd_go) begin
                  st_ff <= tsi_pkg::ST_RD;
                  sda_oe_n_ff <= rd_data[7];
                  txreg_ff <= {rd_data[6:0], 1'b0};
                  cnt_ff <= 4'h0;
                  ptr_ff <= ptr_ff + 8'h01;
               end else if (scl_fall && ack_rise_ff) begin
                  st_ff <= tsi_pkg::ST_WR;
                  sda_oe_n_ff <= 1'b1;
                  cnt_ff <= 4'h0;
               end
            end
            tsi_pkg::ST_RD: begin
               if (scl_rise) begin
                  cnt_ff <= cnt_ff + 4'h1;
               end else if (byte_done) begin
                  // free the line for the master's answer
                  st_ff <= tsi_pkg::ST_MACK;
                  sda_oe_n_ff <= 1'b1;
                  more_ff <= 1'b0;
               end else if (scl_fall) begin
                  sda_oe_n_ff <= txreg_ff[7];
                  txreg_ff <= {txreg_ff[6:0], 1'b0};
               end
            end
            tsi_pkg::ST_MACK: begin
               if (scl_rise) begin
                  more_ff <= ~sda_s;
               end else if (rd_go) begin
                  st_ff <= tsi_pkg::ST_RD;
                  sda_oe_n_ff <= rd_data[7];
                  txreg_ff <= {rd_data[6:0], 1'b0};
                  cnt_ff <= 4'h0;
                  ptr_ff <= ptr_ff + 8'h01;
               end else if (scl_fall) begin
                  // not acknowledged: stay off the line until next start
                  st_ff <= tsi_pkg::ST_IDLE;
                  sda_oe_n_ff <= 1'b1;
               end
            end
            default: begin
               st_ff <= tsi_pkg::ST_IDLE;
               sda_oe_n_ff <= 1'b1;
            end
         endcase
      end
   end

   // open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_n = sda_oe_n_ff;

   // ********************************************************
   // interrupt source and status
   // ********************************************************
   logic [7:0] irq_ff;
   logic [7:0] evt_bits;
   logic irq_clear;
   logic [5:0] key_idx;
   logic [2:0] burns_shown;
   logic stored_in_use;

   // the core already reports within one scan period of the event
   always_comb begin
      evt_bits = 8'h00;
      evt_bits[`TSI_IRQ_BURN] = events.burn_done;
      evt_bits[`TSI_IRQ_PWRITE] = events.param_write_done;
      evt_bits[`TSI_IRQ_SENSOR] = events.sensor_event;
      evt_bits[`TSI_IRQ_COMP] = events.comp_done;
      evt_bits[`TSI_IRQ_MODE] = events.mode_entered;
   end

   assign irq_clear = rd_go && (ptr_ff == `TSI_OFS_IRQ);

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 8'h00;
      end else begin
         irq_ff <= (irq_clear ? 8'h00 : irq_ff) | evt_bits;
      end
   end

   assign interrupt_request_o = 1'b0;
   assign interrupt_request_oe_n = ~|irq_ff;

   // lowest touched key wins, numbered from one
   always_comb begin
      key_idx = 6'h00;
      for (int i = KEYS - 1; i >= 0; i--) begin
         if (keys_touched[i]) begin
            key_idx = 6'(i + 1);
         end
      end
   end

   // beyond three burns the defaults are forced
   assign burns_shown = (burn_count > `TSI_BURN_MAX) ? `TSI_BURN_OVER : burn_count;
   assign stored_in_use = nonvolatile_valid && (burn_count != 3'h0)
                          && (burn_count <= `TSI_BURN_MAX);

   // ********************************************************
   // control and gateway registers
   // ********************************************************
   tsi_pkg::tsi_ctrl_t shadow_ff;
   logic [7:0] srst_ff;
   logic srst_armed_ff;
   logic soft_reset_ff;

   // host control writes land in a shadow copy, the reset byte in srst_ff; status addresses are not written
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shadow_ff <= '0;
         srst_ff <= `TSI_RST_BYTE;
      end else if (soft_reset_ff) begin
         shadow_ff <= '0;
         srst_ff <= `TSI_RST_BYTE;
      end else if (wr_go) begin
         unique case (ptr_ff)
            `TSI_OFS_OPMODE: shadow_ff.op_mode <= shreg_ff;
            `TSI_OFS_GPO: shadow_ff.gpo <= shreg_ff;
            `TSI_OFS_GWCFG: shadow_ff.gw_cfg <= shreg_ff;
            `TSI_OFS_GWBASE: shadow_ff.gw_base <= shreg_ff;
            `TSI_OFS_KEYHI: shadow_ff.key_hi <= shreg_ff;
            `TSI_OFS_KEYLO: shadow_ff.key_lo <= shreg_ff;
            `TSI_OFS_SRST: srst_ff <= shreg_ff;
            default: srst_ff <= srst_ff;
         endcase
      end
   end

   // the core only sees new settings when a phase begins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
      end else if (phase_start) begin
         ctrl <= shadow_ff;
      end
   end

   // two-step unlock guards against a stray single write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         srst_armed_ff <= 1'b0;
         soft_reset_ff <= 1'b0;
      end else begin
         soft_reset_ff <= 1'b0;
         if (soft_reset_ff) begin
            srst_armed_ff <= 1'b0;
         end else if (wr_go && ptr_ff == `TSI_OFS_SRST) begin
            if (srst_armed_ff && shreg_ff == `TSI_SRST_FIRE) begin
               soft_reset_ff <= 1'b1;
               srst_armed_ff <= 1'b0;
            end else begin
               srst_armed_ff <= (shreg_ff == `TSI_SRST_ARM);
            end
         end
      end
   end

   assign soft_reset_pulse = soft_reset_ff;

   // read multiplexer; reserved addresses return zero
   always_comb begin
      unique case (ptr_ff)
         `TSI_OFS_IRQ: rd_data = irq_ff;
         `TSI_OFS_KEYS: rd_data = {1'b0, priority_touched, key_idx};
         `TSI_OFS_MEMST: rd_data = {4'h0, stored_in_use, burns_shown};
         `TSI_OFS_OPMODE: rd_data = shadow_ff.op_mode;
         `TSI_OFS_GPO: rd_data = shadow_ff.gpo;
         `TSI_OFS_GWCFG: rd_data = shadow_ff.gw_cfg;
         `TSI_OFS_GWBASE: rd_data = shadow_ff.gw_base;
         `TSI_OFS_KEYHI: rd_data = shadow_ff.key_hi;
         `TSI_OFS_KEYLO: rd_data = shadow_ff.key_lo;
         `TSI_OFS_SRST: rd_data = srst_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // ********************************************************
   // checks
   // ********************************************************
   chk_irq_pin: assert property (@(posedge clock) disable iff (!rst_n)
      (irq_ff != 8'h00) |-> !interrupt_request_oe_n)
      else $error("interrupt request not driven with a flag set");

   chk_event_sets: assert property (@(posedge clock) disable iff (!rst_n)
      events.sensor_event |=> irq_ff[`TSI_IRQ_SENSOR])
      else $error("sensor event did not set its flag");

   chk_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (irq_clear && evt_bits == 8'h00) |=> (irq_ff == 8'h00) && interrupt_request_oe_n)
      else $error("interrupt source read did not clear");

   chk_ptr_step: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_go || rd_go) && !start_c && !stop_c |=> ptr_ff == $past(ptr_ff) + 8'h01)
      else $error("register pointer did not advance");

   chk_ack_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (st_ff == tsi_pkg::ST_ACK && scl_s) |-> !sda_oe_n)
      else $error("acknowledge released too early");

   chk_nack_release: assert property (@(posedge clock) disable iff (!rst_n)
      (st_ff == tsi_pkg::ST_MACK && scl_fall && !more_ff && !start_c && !stop_c)
      |=> sda_oe_n [*3])
      else $error("data still driven after not-acknowledge");

   chk_key_first: assert property (@(posedge clock) disable iff (!rst_n)
      (keys_touched[0] |-> key_idx == 6'h01) and (keys_touched == '0 |-> key_idx == 6'h00))
      else $error("key index not first touched key");

   chk_phase_apply: assert property (@(posedge clock) disable iff (!rst_n)
      !phase_start |=> ctrl == $past(ctrl))
      else $error("control changed outside a processing phase");

   chk_soft_reset: assert property (@(posedge clock) disable iff (!rst_n)
      soft_reset_pulse |-> $past(srst_armed_ff) && $past(shreg_ff) == `TSI_SRST_FIRE)
      else $error("soft reset without unlock sequence");

   chk_addr_pick: assert property (@(posedge clock) disable iff (!rst_n)
      !stored_addr_valid |-> my_addr == `TSI_DEF_SLAVE_ADDR)
      else $error("default slave address wrong");

   chk_burn_over: assert property (@(posedge clock) disable iff (!rst_n)
      burn_count > `TSI_BURN_MAX |-> burns_shown == `TSI_BURN_OVER && !stored_in_use)
      else $error("burn count over three not reported as four");
endmodule
`default_nettype wire

// [sim/tsi_host.sv]
// two-wire bus master model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module tsi_host (
   // clock
   input wire logic clock,
   // wire level seen, master drive
   input wire logic sda_wire,
   output logic scl,
   output logic sda_m
);
   // ********
   // bus phases
   // ********
   // clock parks high and data is released outside frames
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // data moves mid-low, two clocks clear of either clock edge
   task automatic bit_x(input logic b, output logic s);
      scl <= 1'b0;
      tick(2);
      sda_m <= b;
      tick(2);
      scl <= 1'b1;
      tick(3);
      s = sda_wire;
      tick(1);
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start_c;
      scl <= 1'b0;
      tick(2);
      sda_m <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
   endtask
   // stop: data rises while the clock is high, then both stand still
   task automatic stop_c;
      scl <= 1'b0;
      tick(2);
      sda_m <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b1;
      tick(4);
   endtask
   // byte out msb first, ninth clock reads the acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask
   // byte in; acknowledged only while more bytes are wanted
   task automatic rbyte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         b[i] = s;
      end
      bit_x(~more, s);
   endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of the touch-controller two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int LIMIT = 40000;
   logic clock;
   logic rst_n;
   logic scl;
   logic sda_m;
   logic sda_o;
   logic sda_oe_n;
   logic irq_o;
   logic irq_oe_n;
   tsi_pkg::tsi_evt_t events;
   logic priority_touched;
   logic [35:0] keys_touched;
   logic nonvolatile_valid;
   logic [2:0] burn_count;
   logic stored_addr_valid;
   logic [6:0] stored_addr;
   logic phase_start;
   tsi_pkg::tsi_ctrl_t ctrl;
   logic srst;
   logic [6:0] sa = 7'h2B;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   int n_srst = 0;
   // open-drain wires: pulled up, low when any party pulls
   wire sda_wire = sda_m & (sda_oe_n | sda_o);
   wire irq_pin = irq_oe_n | irq_o;

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   tsi_slave DUT (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .interrupt_request_o(irq_o),
      .interrupt_request_oe_n(irq_oe_n), .events(events),
      .priority_touched(priority_touched), .keys_touched(keys_touched),
      .nonvolatile_valid(nonvolatile_valid), .burn_count(burn_count),
      .stored_addr_valid(stored_addr_valid), .stored_addr(stored_addr),
      .phase_start(phase_start), .ctrl(ctrl), .soft_reset_pulse(srst));
   tsi_host host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));

   // ********
   // bus helpers
   // ********
   task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   // one write transfer, data bytes taken from the top of d
   task automatic wr(input logic [7:0] ra, input logic [31:0] d, input int n);
      logic a;
      host.start_c();
      host.wbyte({sa, 1'b0}, a);
      check(a, 1'b1, "write address ack");
      host.wbyte(ra, a);
      check(a, 1'b1, "register byte ack");
      for (int k = 0; k < n; k++) begin
         host.wbyte(d[31-8*k -: 8], a);
         check(a, 1'b1, "data ack");
      end
      host.stop_c();
   endtask
   // pointer write, repeated start, n bytes gathered low-aligned in q
   task automatic rd(input logic [7:0] ra, input int n, output logic [31:0] q);
      logic a;
      logic [7:0] b;
      q = '0;
      host.start_c();
      host.wbyte({sa, 1'b0}, a);
      host.wbyte(ra, a);
      host.start_c();
      host.wbyte({sa, 1'b1}, a);
      check(a, 1'b1, "read address ack");
      for (int k = 0; k < n; k++) begin
         host.rbyte(k < n - 1, b);
         q = {q[23:0], b};
      end
      host.stop_c();
      check(sda_oe_n, 1'b1, "data released after nack");
   endtask

   // ********
   // scenarios
   // ********
   task automatic t_reset;
      logic [31:0] q;
      check(irq_oe_n, 1'b1, "request idle");
      check(ctrl, '0, "control reset");
      rd(8'h00, 1, q);
      check(q, 32'h0, "flags reset");
   endtask
   // control values held back until a processing phase
   task automatic t_ctrl;
      logic [31:0] q;
      wr(8'h09, 32'h015A_0000, 2);
      wr(8'h0D, 32'h0878_0000, 2);
      wr(8'hAC, 32'h629D_0000, 2);
      check(ctrl, '0, "control held until phase");
      phase_start <= 1'b1;
      @(posedge clock);
      phase_start <= 1'b0;
      repeat (2) @(posedge clock);
      check(ctrl, 48'h015A_0878_629D, "control at phase");
      rd(8'h09, 2, q);
      check(q, 32'h015A, "mode and output back");
      rd(8'hAC, 2, q);
      check(q, 32'h629D, "burn keys back");
      wr(8'h0D, 32'h0040_0000, 2);
      rd(8'h0D, 2, q);
      check(q, 32'h0040, "gateway back");
   endtask
   // each source alone, then all at once
   task automatic t_irq;
      logic [31:0] q;
      logic [7:0] flag [5] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h40};
      for (int k = 0; k < 5; k++) begin
         events <= 5'(1 << k);
         @(posedge clock);
         events <= '0;
         @(posedge clock);
         @(posedge clock);
         check(irq_pin, 1'b0, "request on flag");
         rd(8'h00, 1, q);
         check(q, 32'(flag[k]), "single flag");
         check(irq_pin, 1'b1, "request released");
      end
      events <= 5'h1F;
      @(posedge clock);
      events <= '0;
      rd(8'h00, 1, q);
      check(q, 32'h67, "all flags");
      rd(8'h00, 1, q);
      check(q, 32'h0, "flags cleared");
   endtask
   task automatic t_status;
      logic [31:0] q;
      priority_touched <= 1'b1;
      keys_touched <= 36'h0_0000_0210;
      nonvolatile_valid <= 1'b1;
      burn_count <= 3'h2;
      rd(8'h01, 1, q);
      check(q, 32'h45, "priority and first key");
      rd(8'h08, 1, q);
      check(q, 32'h0A, "valid, two burns");
      // status and reserved places swallow writes
      wr(8'h01, 32'hFFFF_0000, 2);
      priority_touched <= 1'b0;
      keys_touched <= 36'h8_0000_0000;
      burn_count <= 3'h5;
      rd(8'h00, 3, q);
      check(q, 32'h0_2400, "last key, reserved zero");
      rd(8'h07, 2, q);
      check(q, 32'h0004, "over three burns");
   endtask
   task automatic t_addr;
      logic [31:0] q;
      logic a;
      keys_touched <= 36'h8_0000_0001;
      host.start_c();
      host.wbyte({7'h2C, 1'b0}, a);
      host.stop_c();
      check(a, 1'b0, "foreign address refused");
      stored_addr_valid <= 1'b1;
      stored_addr <= 7'h35;
      sa = 7'h35;
      rd(8'h01, 1, q);
      check(q, 32'h01, "stored address, first key");
      host.start_c();
      host.wbyte({7'h2B, 1'b0}, a);
      host.stop_c();
      check(a, 1'b0, "default overridden");
      stored_addr_valid <= 1'b0;
      sa = 7'h2B;
   endtask
   // a foreign byte between arm and fire must disarm
   task automatic t_srst;
      logic [31:0] q;
      wr(8'hB1, 32'hDE00_0000, 1);
      wr(8'hB1, 32'h1100_0000, 1);
      wr(8'hB1, 32'h0, 1);
      check(n_srst, 0, "disarmed reset");
      wr(8'hB1, 32'hDE00_0000, 1);
      wr(8'hB1, 32'h0, 1);
      check(n_srst, 1, "soft reset fired");
      // written control values do not survive the soft reset in the shadow copy
      rd(8'h0D, 2, q);
      check(q, 32'h0, "gateway cleared by soft reset");
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // pulse counter and hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (srst === 1'b1) begin
         n_srst <= n_srst + 1;
      end
      if (cycles == LIMIT) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      rst_n = 1'b0;
      events = '0;
      priority_touched = 1'b0;
      keys_touched = '0;
      nonvolatile_valid = 1'b0;
      burn_count = 3'h0;
      stored_addr_valid = 1'b0;
      stored_addr = 7'h00;
      phase_start = 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
      t_ctrl();
      t_irq();
      t_status();
      t_addr();
      t_srst();
      tally_and_finish();
   end
endmodule
`default_nettype wire
